//--- hdl/wdfl_params.svh
// Contract
// [RL1] a write to the watchdog control register takes effect only when the instruction just before it set the write-unlock bit.
// [RL2] software should mask interrupts globally around the unlock-then-write pair so nothing separates the two instructions.
// [RL3] software may disable the watchdog by clearing its enable bit in a write that directly follows the unlock.
// [RL4] with the lock bit of the configuration byte at zero, enable and response-select are forced on and to reset.
// [RL5] the four-bit timeout prescaler stays writable even while the lock bit is cleared.
// [RL6] the key default reads 0x7F instead of 0xFF whenever the lock bit is cleared.
// [RL7] a protection change is written to flash 0x3FFF down to 0x3FFB only when the stored key matches the key register.
// [RL8] a timeout gives a system reset, or the watchdog interrupt when response-select is set.
// [RL9] the watchdog interrupt is always high priority with no priority setting.
// [RL10] the watchdog interrupt is delivered even with the global enable clear and all else masked.
// [RL11] timeout is two to the prescaler value times 512 input-clock periods; codes above 1001 are invalid. Codes 1000 and 1001 time out on every tick.
// [RL12] the status flag sets on every timeout and clears only by a zero write or external reset.
// [RL13] writing the enable bit to one clears the counter and enables the watchdog.
// [RL14] the configuration byte is sampled at reset and its lock state and key default held until the next reset.
// [RL15] the write unlock lapses after one instruction.
`ifndef WDFL_PARAMS_SVH
`define WDFL_PARAMS_SVH
`define WDFL_CTRL_ADDR   8'hC0
`define WDFL_CFG_ADDR    16'h3FFA
`define WDFL_PROT_HI     16'h3FFF
`define WDFL_PROT_LO     16'h3FFB
`define WDFL_BIT_WR      0
`define WDFL_BIT_EN      1
`define WDFL_BIT_STAT    2
`define WDFL_BIT_RESP    3
`define WDFL_PRE_LSB     4
`define WDFL_LOCK_BIT    7
`define WDFL_PRE_RST     4'h7
`define WDFL_PRE_MAX     4'h9
`define WDFL_PRE_AUTO    4'h8
`define WDFL_BASE_SHIFT  9
`define WDFL_KEY_DEF     8'hFF
`define WDFL_KEY_LOCKED  8'h7F
`define WDFL_TICK_HZ     32768
`define WDFL_CLK_HZ      40000000
`endif

//--- hdl/wdfl_pkg.sv
package wdfl_pkg;
  typedef struct packed {
    logic        unlock;
    logic        en;
    logic        resp;
    logic        stat;
    logic [3:0]  pre;
    logic [15:0] cnt;
    logic        tick_in_s1;
    logic        tick_in_s2;
    logic        tick_prev;
    logic        locked;
    logic [7:0]  key_default;
    logic        cfg_taken;
    logic        sys_reset_req;
    logic        irq;
    logic        prot_wr;
    logic        prot_fail;
    logic [7:0]  rdata;
  } wdfl_state_t;
endpackage : wdfl_pkg

//--- hdl/wdfl_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdfl_params.svh"
module wdfl_watchdog
  import wdfl_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       ext_hw_rst,
  input  wire logic       clkin_32k,
  input  wire logic       instr_done,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic [7:0] cfg_byte,
  input  wire logic       prot_req,
  input  wire logic [7:0] key_compare_register,
  output logic [7:0]      sfr_rdata,
  output logic [7:0]      key_default,
  output logic            dog_sys_reset,
  output logic            dog_irq_hi,
  output logic            prot_write,
  output logic            prot_fail
);
  wdfl_state_t s, n;

  // ==========================================
  // helpers
  function automatic logic [15:0] limit_of(input logic [3:0] pre);
    logic [15:0] v;
    v = 16'h0;
    if (pre <= `WDFL_PRE_MAX) begin
      v = 16'(32'd1 << (pre + `WDFL_BASE_SHIFT)) - 16'h1; // [RL11]
    end
    if (pre == `WDFL_PRE_RST) begin
      v = 16'hFFFF;
    end
    if (pre >= `WDFL_PRE_AUTO) begin
      v = 16'h0;
    end
    return v;
  endfunction : limit_of

  logic ctrl_wr;
  logic tick;
  logic expired;
  logic [7:0] ctrl_view;

  // ==========================================
  // next state
  always_comb begin
    n = s;
    n.tick_in_s1 = clkin_32k;
    n.tick_in_s2 = s.tick_in_s1;
    n.tick_prev = s.tick_in_s2;
    tick = s.tick_in_s2 & ~s.tick_prev;
    n.sys_reset_req = 1'b0;
    n.irq = 1'b0;
    n.prot_wr = 1'b0;
    n.prot_fail = 1'b0;
    // strap is caught in the first clocked cycle after release, never under reset
    if (!s.cfg_taken) begin
      n.cfg_taken = 1'b1;
      n.locked = ~cfg_byte[`WDFL_LOCK_BIT]; // [RL14]
      n.key_default = cfg_byte[`WDFL_LOCK_BIT] ? `WDFL_KEY_DEF : `WDFL_KEY_LOCKED; // [RL6]
    end
    ctrl_wr = sfr_wr && (sfr_addr == `WDFL_CTRL_ADDR);
    // codes above 1001 never time out; with an invalid selection the counter keeps counting and wrapping rather than firing
    expired = s.en && (s.pre <= `WDFL_PRE_MAX) && tick && (s.cnt >= limit_of(s.pre));
    if (s.en && tick) begin
      n.cnt = expired ? 16'h0 : s.cnt + 16'h1;
    end
    if (instr_done && !ctrl_wr) begin
      n.unlock = 1'b0; // [RL15]
    end
    if (ctrl_wr) begin
      if (s.unlock) begin // [RL1]
        n.unlock = 1'b0;
        n.pre = sfr_wdata[`WDFL_PRE_LSB +: 4]; // [RL5]
        if (!s.locked) begin // [RL4]
          n.en = sfr_wdata[`WDFL_BIT_EN]; // [RL3]
          n.resp = sfr_wdata[`WDFL_BIT_RESP];
        end
        if (sfr_wdata[`WDFL_BIT_EN]) begin
          n.cnt = 16'h0; // [RL13]
        end
        if (!sfr_wdata[`WDFL_BIT_STAT]) begin
          n.stat = 1'b0;
        end
      end else begin
        n.unlock = sfr_wdata[`WDFL_BIT_WR];
      end
    end
    if (s.locked) begin
      n.en = 1'b1; // [RL4]
      n.resp = 1'b0;
    end
    if (expired) begin
      n.stat = 1'b1; // [RL12]
      // interrupt bypasses the global enable and priority logic [RL9] [RL10]
      if (s.resp) begin
        n.irq = 1'b1; // [RL8]
      end else begin
        n.sys_reset_req = 1'b1; // [RL8]
      end
    end
    if (prot_req) begin
      if (key_compare_register == s.key_default) begin // [RL7]
        n.prot_wr = 1'b1;
      end else begin
        n.prot_fail = 1'b1;
      end
    end
    ctrl_view = {s.pre, s.resp, s.stat, s.en, s.unlock};
    n.rdata = (sfr_rd && sfr_addr == `WDFL_CTRL_ADDR) ? ctrl_view : 8'h00;
  end

  // ==========================================
  // registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s <= '0;
      s.en <= 1'b1;
      s.pre <= `WDFL_PRE_RST;
      s.key_default <= `WDFL_KEY_DEF;
      // a watchdog-caused reset keeps the status flag; only the pin clears it [RL12]
      s.stat <= ext_hw_rst ? 1'b0 : s.stat;
    end else begin
      s <= n;
    end
  end

  assign sfr_rdata = s.rdata;
  assign key_default = s.key_default;
  assign dog_sys_reset = s.sys_reset_req;
  assign dog_irq_hi = s.irq;
  assign prot_write = s.prot_wr;
  assign prot_fail = s.prot_fail;
endmodule : wdfl_watchdog
`default_nettype wire

//--- verif/wdfl_watchdog_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module wdfl_watchdog_asserts (
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       sfr_rd,
  input wire logic       prot_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic [7:0] key_default,
  input wire logic       dog_sys_reset,
  input wire logic       dog_irq_hi,
  input wire logic       prot_write,
  input wire logic       prot_fail
);
  // =====
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_prot_answer;
    prot_write ^ prot_fail;
  endsequence
  AST_PROT_ANSWER: assert property (prot_req |=> s_prot_answer) else $error("no protection answer");
  AST_PROT_CAUSE: assert property ((prot_write || prot_fail) |-> $past(prot_req)) else $error("stray answer");
  AST_KEY_VALUE: assert property (key_default == 8'hFF || key_default == 8'h7F) else $error("bad key");
  AST_KEY_HELD: assert property (!$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3)
    |-> $stable(key_default)) else $error("key moved");
  AST_RDATA_IDLE: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00) else $error("rdata not idle");
  AST_OUTCOME_EXCL: assert property (!(dog_sys_reset && dog_irq_hi)) else $error("both outcomes");
  AST_IRQ_PULSE: assert property (dog_irq_hi |=> !dog_irq_hi) else $error("irq too long");
  AST_RST_PULSE: assert property ($rose(dog_sys_reset) |=> $fell(dog_sys_reset)) else $error("reset too long");
endmodule : wdfl_watchdog_asserts
bind wdfl_watchdog wdfl_watchdog_asserts u_wdfl_watchdog_asserts (.*);
`default_nettype wire

//--- verif/wdfl_watchdog_tb.sv
`timescale 1ns/1ps
`default_nettype none
module wdfl_watchdog_tb;
  import wdfl_pkg::*;
  logic ref_clk = 0, sys_rst = 1, ext_hw_rst = 1, clkin_32k = 0, instr_done = 0, sfr_wr = 0, sfr_rd = 0, prot_req = 0;
  logic [7:0] sfr_addr = 8'hC0, sfr_wdata = 8'h00, cfg_byte = 8'hFF, key_compare_register = 8'hFF;
  logic [7:0] sfr_rdata, key_default;
  logic dog_sys_reset, dog_irq_hi, prot_write, prot_fail;
  int n_mismatch = 0;
  int comparisons = 0;
  wdfl_watchdog u_wdfl_watchdog (.*);
  // =====
  // tasks
  initial forever #12.5 ref_clk = ~ref_clk;
  // fast slow-clock: toggles land on falling edges, keeps timeouts short
  initial forever #50 clkin_32k = ~clkin_32k;
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("n_mismatch=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic rs(input logic [7:0] cfg, input logic ext);
    @(negedge ref_clk) sys_rst = 1;
    ext_hw_rst = ext;
    cfg_byte = cfg;
    repeat (20) @(negedge ref_clk);
    sys_rst = 0;
    ext_hw_rst = 0;
  endtask : rs
  task automatic wr(input logic [7:0] d);
    @(negedge ref_clk) sfr_wr = 1;
    sfr_wdata = d;
    @(negedge ref_clk) sfr_wr = 0;
  endtask : wr
  task automatic uw(input logic [7:0] d);
    wr(8'h01);
    wr(d);
  endtask : uw
  task automatic rd(input logic [7:0] exp);
    @(negedge ref_clk) sfr_rd = 1;
    @(negedge ref_clk) sfr_rd = 0;
    chk("control", sfr_rdata, exp);
  endtask : rd
  task automatic pr(input logic [7:0] k, input logic [7:0] exp);
    @(negedge ref_clk) prot_req = 1;
    key_compare_register = k;
    @(negedge ref_clk) prot_req = 0;
    chk("prot", {6'h00, prot_write, prot_fail}, exp);
  endtask : pr
  task automatic wt(input logic irq);
    comparisons++;
    for (int i = 0; i < 3000; i++) begin
      @(negedge ref_clk);
      if ((irq ? dog_irq_hi : dog_sys_reset) === 1'b1) return;
    end
    n_mismatch++;
    $display("FAIL timeout never came");
    tally_and_finish();
  endtask : wt
  // =====
  // sequence
  initial begin
    rs(8'hFF, 1'b1);
    rd(8'h72);
    chk("key", key_default, 8'hFF);
    sfr_addr = 8'hC1;
    rd(8'h00);
    sfr_addr = 8'hC0;
    wr(8'h70);
    rd(8'h72);
    wr(8'h01);
    @(negedge ref_clk) instr_done = 1;
    @(negedge ref_clk) instr_done = 0;
    wr(8'h70);
    rd(8'h72);
    uw(8'h08);
    rd(8'h08);
    uw(8'h0A);
    wt(1'b1);
    rd(8'h0E);
    pr(8'hFF, 8'h02);
    pr(8'h00, 8'h01);
    rs(8'h7F, 1'b0);
    rd(8'h76);
    chk("key", key_default, 8'h7F);
    uw(8'h08);
    rd(8'h02);
    wt(1'b0);
    tally_and_finish();
  end
endmodule : wdfl_watchdog_tb
`default_nettype wire
